//--- logic/eil_ext_int_latch.sv
// External interrupt latch with APB register access
`timescale 1ns/100ps
module eil_ext_int_latch (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Pin and CPU side
	input wire logic irq_n_i,
	input wire logic vector_fetch_i,
	input wire logic break_state_i,
	output logic cpu_irq_o,
	output logic [15:0] vector_addr_hi_o,
	output logic [15:0] vector_addr_lo_o,
	output logic pin_level_o
);
	import eil_pkg::*;

	// ************
	// Elaboration checks
	// ************
	// Field and offset sanity
	localparam int WORD_TOP = 31;
	localparam logic [1:0] FILL_DONE = 2'h3;
	localparam bit FIELDS_FIT = (EIL_MODE_BIT <= WORD_TOP) && (EIL_MASK_BIT <= WORD_TOP)
		&& (EIL_ACK_BIT <= WORD_TOP) && (EIL_FLAG_BIT <= WORD_TOP)
		&& (EIL_BREAK_CLEAR_ENABLE_BIT <= WORD_TOP);
	localparam bit FIELDS_APART = (EIL_MODE_BIT != EIL_MASK_BIT)
		&& (EIL_MODE_BIT != EIL_ACK_BIT) && (EIL_MODE_BIT != EIL_FLAG_BIT)
		&& (EIL_MASK_BIT != EIL_ACK_BIT) && (EIL_MASK_BIT != EIL_FLAG_BIT)
		&& (EIL_ACK_BIT != EIL_FLAG_BIT);
	localparam bit OFFS_OK = (EIL_SCR_OFF[1:0] == 2'h0) && (EIL_BRK_OFF[1:0] == 2'h0)
		&& (EIL_SCR_OFF != EIL_BRK_OFF);

	// Refuse a field map that the decode and readback cannot serve
	if (!FIELDS_FIT) begin : g_fields_fit
		$error("Register field outside the data word");
	end
	if (!FIELDS_APART) begin : g_fields_apart
		$error("Register fields overlap");
	end
	if (!OFFS_OK) begin : g_offs_ok
		$error("Register offsets are not distinct aligned words");
	end

	// ************
	// Pin sampling
	// ************
	logic pin_sync;
	logic prev_r;
	logic [1:0] fill_r;
	logic fill_done;
	logic fall;
	logic pin_low;

	// Two flip-flops before any logic reads the pin
	eil_pin_sync #(
		.STAGES(2),
		.IDLE_LVL(1'b1)
	) eil_pin_sync_inst (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.pin_i(irq_n_i),
		.sync_o(pin_sync)
	);

	// History stage holds the previous clock's sample
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			prev_r <= 1'b1;
		end else begin
			prev_r <= pin_sync;
		end
	end

	// Reset values in the chain are not real samples: a pin held low
	// through reset must not look like a falling edge after release
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			fill_r <= 2'h0;
		end else if (!fill_done) begin
			fill_r <= fill_r + 2'h1;
		end
	end
	assign fill_done = (fill_r == FILL_DONE);

	// High sample then low sample on the next clock
	assign fall = prev_r & ~pin_sync & fill_done;
	assign pin_low = ~pin_sync;

	// ************
	// Register decode
	// ************
	logic scr_sel;
	logic brk_sel;
	logic access;
	logic rd_setup;
	logic wr_en;

	// Word decode
	assign scr_sel = (paddr_i == EIL_SCR_OFF);
	assign brk_sel = (paddr_i == EIL_BRK_OFF);
	// Access phase of any transfer; the slave never stretches it
	assign access = psel_i & penable_i;
	// Read data is captured in the setup cycle and stands through the access phase
	assign rd_setup = psel_i & ~penable_i & ~pwrite_i;
	assign wr_en = access & pwrite_i;
	assign pready_o = 1'b1;
	// Unmapped words answer with an error; writes to them are dropped
	assign pslverr_o = access & ~scr_sel & ~brk_sel;

	// ************
	// Control registers
	// ************
	logic mode_r;
	logic mask_r;
	logic break_clear_enable_r;
	logic mode_nxt;
	logic mask_nxt;
	logic break_clear_enable_nxt;

	// Field writes of the status and control word
	always_comb begin
		mode_nxt = mode_r;
		mask_nxt = mask_r;
		if (wr_en & scr_sel) begin
			mode_nxt = pwdata_i[EIL_MODE_BIT];
			mask_nxt = pwdata_i[EIL_MASK_BIT];
		end
	end

	always_comb begin
		break_clear_enable_nxt = break_clear_enable_r;
		if (wr_en & brk_sel) begin
			break_clear_enable_nxt = pwdata_i[EIL_BREAK_CLEAR_ENABLE_BIT];
		end
	end

	// Sensitivity select, edge-only out of reset
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			mode_r <= EIL_MODE_RST;
		end else begin
			mode_r <= mode_nxt;
		end
	end

	// Request mask, clear out of reset
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			mask_r <= EIL_MASK_RST;
		end else begin
			mask_r <= mask_nxt;
		end
	end

	// Break clear enable, clear out of reset
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			break_clear_enable_r <= EIL_BREAK_CLEAR_ENABLE_RST;
		end else begin
			break_clear_enable_r <= break_clear_enable_nxt;
		end
	end

	// ************
	// Acknowledge
	// ************
	logic brk_block;
	logic sw_ack;
	logic vec_ack;
	logic ack;
	logic req_pend;

	// In break with clear-enable low an acknowledge write is dropped
	assign brk_block = break_state_i & ~break_clear_enable_r;
	// A one in the acknowledge bit; the bit itself stores nothing
	assign sw_ack = wr_en & scr_sel & pwdata_i[EIL_ACK_BIT] & ~brk_block;
	// A vector fetch acknowledges any pending request, masked or not
	assign vec_ack = vector_fetch_i & req_pend;
	assign ack = sw_ack | vec_ack;

	// ************
	// Request state
	// ************
	// Acked remembers an acknowledge taken while the pin was still low
	typedef enum logic [1:0] {
		EIL_REQ_IDLE = 2'b00,
		EIL_REQ_PEND = 2'b01,
		EIL_REQ_ACKED = 2'b10
	} eil_req_t;
	eil_req_t state_r;
	eil_req_t state_nxt;

	// Next request state
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			EIL_REQ_IDLE: begin
				// Any falling edge latches, also after an acknowledge
				if (fall) begin
					state_nxt = EIL_REQ_PEND;
				end
			end
			EIL_REQ_PEND: begin
				if (fall) begin
					// Set wins over a simultaneous acknowledge
					state_nxt = EIL_REQ_PEND;
				end else if (ack & mode_r & pin_low) begin
					// Still pending while the pin stays low
					state_nxt = EIL_REQ_ACKED;
				end else if (ack) begin
					state_nxt = EIL_REQ_IDLE;
				end
			end
			EIL_REQ_ACKED: begin
				if (fall) begin
					state_nxt = EIL_REQ_PEND;
				end else if (~mode_r) begin
					// Back in edge-only mode the request waits for a fresh acknowledge
					state_nxt = EIL_REQ_PEND;
				end else if (~pin_low) begin
					// Pin back high after the acknowledge
					state_nxt = EIL_REQ_IDLE;
				end
			end
			default: begin
				state_nxt = EIL_REQ_IDLE;
			end
		endcase
	end

	// Reset removes any request even with the pin low
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_r <= EIL_REQ_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign req_pend = (state_r != EIL_REQ_IDLE);

	// ************
	// Outputs
	// ************
	// Masked requests never reach the priority logic
	assign cpu_irq_o = req_pend & ~mask_r;
	assign vector_addr_hi_o = EIL_VEC_HI;
	assign vector_addr_lo_o = EIL_VEC_LO;
	// Synchronised pin level, high while the pin is high
	assign pin_level_o = pin_sync;

	// ************
	// Readback
	// ************
	logic [31:0] rd_nxt;

	// Flag shows the request regardless of the mask; acknowledge reads zero
	always_comb begin
		rd_nxt = 32'h0;
		if (scr_sel) begin
			rd_nxt[EIL_MODE_BIT] = mode_r;
			rd_nxt[EIL_MASK_BIT] = mask_r;
			rd_nxt[EIL_FLAG_BIT] = req_pend;
		end else if (brk_sel) begin
			rd_nxt[EIL_BREAK_CLEAR_ENABLE_BIT] = break_clear_enable_r;
		end
	end

	// Captured in the setup cycle so the word stands through the access phase
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			prdata_o <= 32'h0;
		end else if (rd_setup) begin
			prdata_o <= rd_nxt;
		end
	end
endmodule // eil_ext_int_latch

// ************
// Pin synchroniser
// ************
module eil_pin_sync #(
	parameter int STAGES = 2,
	parameter logic IDLE_LVL = 1'b1
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Raw pin and synchronised level
	input wire logic pin_i,
	output logic sync_o
);
	logic [STAGES-1:0] chain_r;

	// A single stage cannot settle a metastable sample
	if (STAGES < 2) begin : g_stages_ok
		$error("Synchroniser needs at least two stages");
	end

	// Reset level matches the idle pin
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			chain_r <= {STAGES{IDLE_LVL}};
		end else begin
			chain_r <= {chain_r[STAGES-2:0], pin_i};
		end
	end

	assign sync_o = chain_r[STAGES-1];
endmodule // eil_pin_sync

//--- pkg/eil_pkg.sv
// Constants for the external interrupt latch block
package eil_pkg;
	// Register word offset (byte address)
	localparam logic [7:0] EIL_SCR_OFF = 8'h00;
	localparam logic [7:0] EIL_BRK_OFF = 8'h04;
	// Status and control field positions
	localparam int EIL_MODE_BIT = 0;
	localparam int EIL_MASK_BIT = 1;
	localparam int EIL_ACK_BIT = 2;
	localparam int EIL_FLAG_BIT = 3;
	// Break control field position
	localparam int EIL_BREAK_CLEAR_ENABLE_BIT = 0;
	// Reset values
	localparam logic EIL_MODE_RST = 1'b0;
	localparam logic EIL_MASK_RST = 1'b0;
	localparam logic EIL_BREAK_CLEAR_ENABLE_RST = 1'b0;
	// Handler vector locations
	localparam logic [15:0] EIL_VEC_HI = 16'hfffa;
	localparam logic [15:0] EIL_VEC_LO = 16'hfffb;
endpackage

//--- bench/eil_pin_model.sv
// Driver model for the active-low interrupt pin
`timescale 1ns/100ps
module eil_pin_model (
	// Clock and requested level
	input wire logic clk_i,
	input wire logic lvl_i,
	// Pin
	output logic irq_n_o
);
	// Pull-up keeps the pin high until driven
	initial irq_n_o = 1'b1;
	always @(posedge clk_i) irq_n_o <= lvl_i;
endmodule // eil_pin_model

//--- bench/eil_chk_asserts.sv
// Port checker for the external interrupt latch
`timescale 1ns/100ps
module eil_chk import eil_pkg::*; (
	input wire logic clk_i, rst_i, psel_i, penable_i, pwrite_i,
	input wire logic break_state_i, irq_n_i, cpu_irq_o, pin_level_o,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i, prdata_o,
	input wire logic [15:0] vector_addr_hi_o, vector_addr_lo_o
);
	logic mk_r, md_r;
	logic [1:0] up_r;
	wire w0 = psel_i && penable_i && pwrite_i && paddr_i == EIL_SCR_OFF;
	wire wa = w0 && pwdata_i[EIL_ACK_BIT] && !break_state_i;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Shadow of mask and mode
	always_ff @(posedge clk_i or posedge rst_i)
		if (rst_i) {mk_r, md_r} <= 2'h0;
		else if (w0) {mk_r, md_r} <= pwdata_i[1:0];
	// Edges since reset release, saturating once the sampling chain holds real samples
	always_ff @(posedge clk_i or posedge rst_i)
		if (rst_i) up_r <= 2'h0;
		else if (up_r != 2'h3) up_r <= up_r + 2'h1;
	a_rst_quiet: assert property (up_r != 2'h3 |-> !cpu_irq_o)
		else $error("request right after reset");
	a_vec_const: assert property (
		vector_addr_hi_o == EIL_VEC_HI && vector_addr_lo_o == EIL_VEC_LO) else $error("vector");
	a_ack_reads0: assert property (
		psel_i && penable_i && !pwrite_i |-> !prdata_o[EIL_ACK_BIT]) else $error("ack read");
	a_pin_follow: assert property ($fell(irq_n_i) |-> ##[1:3] !pin_level_o)
		else $error("pin level");
	a_rst_clear: assert property (!rst_i && $past(rst_i) |-> !cpu_irq_o)
		else $error("reset");
	a_edge_set: assert property ($fell(pin_level_o) && !mk_r && up_r == 2'h3 |-> ##[0:2] cpu_irq_o)
		else $error("edge");
	a_mask_gate: assert property (mk_r |-> !cpu_irq_o) else $error("mask");
	a_ack_clear: assert property (wa && pin_level_o && irq_n_i |=> !cpu_irq_o)
		else $error("ack");
	a_level_hold: assert property (
		md_r && !w0 && !pin_level_o && cpu_irq_o |=> cpu_irq_o || mk_r) else $error("level");
endmodule // eil_chk
bind eil_ext_int_latch eil_chk eil_chk_inst (.*);

//--- bench/tb_eil_ext_int_latch.sv
// Self-checking bench for the external interrupt latch
`timescale 1ns/100ps
module tb_eil_ext_int_latch;
	import eil_pkg::*;
	localparam logic [7:0] S = EIL_SCR_OFF, B = EIL_BRK_OFF;
	localparam logic [31:0] MD = 1 << EIL_MODE_BIT, MK = 1 << EIL_MASK_BIT;
	localparam logic [31:0] AK = 1 << EIL_ACK_BIT, FL = 1 << EIL_FLAG_BIT;
	logic clk_i = 0, rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0, lvl = 1;
	logic vector_fetch_i = 0, break_state_i = 0, irq_n_i, pready_o, pslverr_o;
	logic cpu_irq_o, pin_level_o, err;
	logic [7:0] paddr_i = 0;
	logic [31:0] pwdata_i = 0, prdata_o;
	logic [15:0] vector_addr_hi_o, vector_addr_lo_o;
	int n_mismatch = 0, checked = 0;
	always #2 clk_i = ~clk_i;
	eil_pin_model eil_pin_model_inst (.clk_i, .lvl_i(lvl), .irq_n_o(irq_n_i));
	eil_ext_int_latch eil_ext_int_latch_inst (.*);
	task ch(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("FAIL %s exp %h got %h", nm, e, g);
		end
	endtask
	task x(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		{psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'h2, w, a, d};
		@(posedge clk_i);
		penable_i <= 1;
		do @(posedge clk_i); while (pready_o !== 1'b1);
		err = pslverr_o;
		{psel_i, penable_i} <= 2'h0;
	endtask
	task r(input logic [7:0] a, input logic [31:0] e);
		x(0, a, 0);
		ch("prdata", e, prdata_o);
	endtask
	task p(input logic v);
		lvl <= v;
		repeat (6) @(posedge clk_i);
	endtask
	task results;
		if (n_mismatch == 0 && checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		#40000;
		n_mismatch++;
		results();
	end
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 0;
		r(S, 0);
		ch("pslverr", 0, err);
		r(B, 0);
		r(8'h08, 0);
		ch("pslverr", 1, err);
		p(0);
		ch("pin", 0, pin_level_o);
		ch("irq", 1, cpu_irq_o);
		x(1, S, MK);
		r(S, MK | FL);
		ch("irq", 0, cpu_irq_o);
		x(1, S, MK | AK);
		r(S, MK);
		p(1);
		p(0);
		r(S, MK | FL);
		vector_fetch_i <= 1;
		@(posedge clk_i);
		vector_fetch_i <= 0;
		r(S, MK);
		x(1, S, MD);
		p(1);
		p(0);
		x(1, S, MD | AK);
		r(S, MD | FL);
		ch("irq", 1, cpu_irq_o);
		p(1);
		r(S, MD);
		x(1, S, 0);
		p(0);
		break_state_i <= 1;
		x(1, S, AK);
		r(S, FL);
		x(1, B, 1 << EIL_BREAK_CLEAR_ENABLE_BIT);
		x(1, S, AK);
		break_state_i <= 0;
		r(S, 0);
		p(1);
		p(0);
		x(1, S, MD | MK);
		rst_i <= 1;
		repeat (2) @(posedge clk_i);
		rst_i <= 0;
		r(S, 0);
		p(0);
		r(S, 0);
		ch("irq", 0, cpu_irq_o);
		results();
	end
endmodule // tb_eil_ext_int_latch
